/* common/scrs_defs.svh */
// Constants of the system clock and reset sequencer.
// Assumes inclusion by bare name from the core.
`ifndef SCRS_DEFS_SVH
`define SCRS_DEFS_SVH
// Recovery counter terminal values, one below each documented cycle count.
`define SCRS_CNT_W 12
`define SCRS_STAB_LAST 12'hFFF
`define SCRS_TAIL_LAST 12'h03F
`define SCRS_SHORT_LAST 12'h01F
// A service write clears stages 12 to 5, so only the low four bits survive.
`define SCRS_SVC_KEEP 12'h00F
`define SCRS_SVC_ADDR 16'hFFFF
`define SCRS_VEC_USER 16'hFFFE
`define SCRS_VEC_MON 16'hFEFE
`define SCRS_ERASED 8'hFF
// Reset cause layout.
`define SCRS_CAUSE_POR 7
`define SCRS_CAUSE_WDT 5
`define SCRS_CAUSE_ILLEGAL_OPCODE_FLAG 4
`define SCRS_CAUSE_ILLEGAL_ADDRESS_FLAG 3
`define SCRS_CAUSE_BLANK 2
`define SCRS_CAUSE_LVR 1
`define SCRS_CAUSE_RESET 8'h80
`define SCRS_WDT_BITS 8
`endif

/* common/scrs_pkg.sv */
// Types shared by the sequencer core and its bench.
// Assumes scrs_defs.svh is on the include path.
package scrs_pkg;
  typedef enum logic [2:0] {
    ST_STAB = 3'b000,
    ST_TAIL = 3'b001,
    ST_RUN = 3'b010,
    ST_WAIT = 3'b011,
    ST_STOP = 3'b100,
    ST_STOP_REC = 3'b101
  } scrs_state_e;

  typedef struct packed {
    logic stop_enable;
    logic short_stop_recovery;
    logic lv_power_disable;
    logic lv_reset_disable;
  } scrs_cfg_s;
endpackage

/* core/scrs_core.sv */
// System clock and reset sequencer: bus clock, clock gating, recovery counter,
// reset source gathering, reset cause and watchdog prescaler.
// Assumes clk_sys_in is the inverted reference clock, so each rising edge here
// is a falling edge of the reference; CPU status inputs share this clock.
//
// How it works
// - Bus clock runs at one quarter of the reference clock in user mode.
// - Power-on or low-voltage reset holds clocks off and reset for 4096 cycles.
// - After that count, reset stays active 64 more cycles before release.
// - Stop exit counts recovery on the reference; clocks stay off until done.
// - Wait mode stops CPU clocks while peripheral clocks keep running.
// - Every reset asserts internal reset and selects FFFE, or FEFE in monitor.
// - Internal reset returns all registers and modules to default; the reset cause and monitor force registers are not cleared by it.
// - Each reset clears the recovery counter and sets its own cause flag.
// - Watchdog reset request is taken asynchronously to the bus clock.
// - Power-on sets only the power-on flag and enables the clock generator.
// - Watchdog counter overflow resets the chip and sets the watchdog flag.
// - Write to FFFF clears watchdog counter and recovery counter stages 12-5.
// - Watchdog disabled only in monitor mode with high voltage on irq pin.
// - Illegal instruction from the CPU sets its flag and resets the chip.
// - Stop with stop-enable at 0 acts as an illegal opcode reset.
// - Only opcode fetches from unmapped addresses reset; data fetches do not.
// - Erased reset vectors trigger a reset that enters monitor mode.
// - Low-voltage trip resets only when both disable bits are 0; held until recovery.
// - Recovery counter is 12 bits on reference falling edge; overflow clocks watchdog.
// - Stop clears the counter; wake delay is 32 cycles if short recovery, else 4096.
// - Outside reset and stop states the recovery counter runs freely.
// - Reset cause is read-only: bits 7,5,4,3,2,1 as documented.
`include "scrs_defs.svh"

module scrs_core #(
  parameter int WDT_BITS = `SCRS_WDT_BITS
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic power_on_pulse_in,
  input wire logic low_voltage_trip_in,
  input wire logic watchdog_req_in,
  input wire logic external_irq_pin_hv_in,
  input wire scrs_pkg::scrs_cfg_s cfg_in,
  input wire logic monitor_mode_in,
  input wire logic illegal_op_in,
  input wire logic stop_exec_in,
  input wire logic wait_exec_in,
  input wire logic wake_in,
  input wire logic opcode_fetch_in,
  input wire logic data_fetch_in,
  input wire logic addr_unmapped_in,
  input wire logic write_in,
  input wire logic [15:0] addr_in,
  input wire logic vector_fetch_in,
  input wire logic [7:0] vector_data_in,
  output logic internal_reset_out,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic internal_bus_clock_out,
  output logic clock_gen_output_out,
  output logic [15:0] reset_vector_out,
  output logic monitor_force_out,
  output logic [7:0] reset_cause_register_out
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (WDT_BITS < 2 || WDT_BITS > 16)
  begin : g_bad_wdt
    $error("WDT_BITS must lie between 2 and 16");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] async_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  assign async_raw = {external_irq_pin_hv_in, watchdog_req_in, low_voltage_trip_in,
                      power_on_pulse_in};

  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
      if (!rstn_in)
      begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end
      else
      begin
        sync1_q[i] <= async_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  logic por_s;
  logic lvi_s;
  logic wd_req_s;
  logic irq_hv_s;
  assign por_s = sync2_q[0];
  assign lvi_s = sync2_q[1];
  assign wd_req_s = sync2_q[2];
  assign irq_hv_s = sync2_q[3];

  // ---------------------------------------------------------------
  // Reset sources
  // ---------------------------------------------------------------
  scrs_pkg::scrs_state_e state_q;
  scrs_pkg::scrs_state_e state_d;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic [WDT_BITS-1:0] wd_cnt_q;
  logic run;
  logic awake;
  logic svc;
  logic wd_disable;
  logic cnt_ovf;
  logic wd_ovf;
  logic lvi_src;
  logic illegal_opcode_flag_src;
  logic illegal_address_flag_src;
  logic blank_src;
  logic wd_src;
  logic long_src;
  logic src_any;

  assign run = (state_q == scrs_pkg::ST_RUN);
  assign awake = run || (state_q == scrs_pkg::ST_WAIT);
  assign svc = run && write_in && (addr_in == `SCRS_SVC_ADDR);
  // Decoded from the synchronised pin with no register of its own, so a noise glitch cannot latch it.
  assign wd_disable = monitor_mode_in && irq_hv_s;
  assign cnt_ovf = awake && !svc && (cnt_q == `SCRS_STAB_LAST);
  assign wd_ovf = cnt_ovf && !wd_disable && (&wd_cnt_q);
  assign lvi_src = lvi_s && !cfg_in.lv_power_disable && !cfg_in.lv_reset_disable;
  assign illegal_opcode_flag_src = run && (illegal_op_in || (stop_exec_in && !cfg_in.stop_enable));
  assign illegal_address_flag_src = run && opcode_fetch_in && addr_unmapped_in;
  assign blank_src = run && vector_fetch_in && (vector_data_in == `SCRS_ERASED);
  assign wd_src = wd_ovf || (wd_req_s && !wd_disable);
  assign long_src = por_s || lvi_src;
  assign src_any = long_src || wd_src || illegal_opcode_flag_src || illegal_address_flag_src || blank_src;

  // ---------------------------------------------------------------
  // Sequencer and recovery counter
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q + 12'h001;
    if (src_any)
    begin
      // Level sources keep the counter cleared until they drop.
      state_d = long_src ? scrs_pkg::ST_STAB : scrs_pkg::ST_TAIL;
      cnt_d = 12'h000;
    end
    else
    begin
      unique case (state_q)
        scrs_pkg::ST_STAB:
        begin
          if (cnt_q == `SCRS_STAB_LAST)
          begin
            state_d = scrs_pkg::ST_TAIL;
          end
        end
        scrs_pkg::ST_TAIL:
        begin
          if (cnt_q == `SCRS_TAIL_LAST)
          begin
            state_d = scrs_pkg::ST_RUN;
          end
        end
        scrs_pkg::ST_RUN:
        begin
          if (stop_exec_in)
          begin
            state_d = scrs_pkg::ST_STOP;
            cnt_d = 12'h000;
          end
          else if (wait_exec_in)
          begin
            state_d = scrs_pkg::ST_WAIT;
          end
          else if (svc)
          begin
            cnt_d = cnt_q & `SCRS_SVC_KEEP;
          end
        end
        scrs_pkg::ST_WAIT:
        begin
          if (wake_in)
          begin
            state_d = scrs_pkg::ST_RUN;
          end
        end
        scrs_pkg::ST_STOP:
        begin
          cnt_d = 12'h000;
          if (wake_in)
          begin
            state_d = scrs_pkg::ST_STOP_REC;
          end
        end
        scrs_pkg::ST_STOP_REC:
        begin
          if (cnt_q == (cfg_in.short_stop_recovery ? `SCRS_SHORT_LAST : `SCRS_STAB_LAST))
          begin
            state_d = scrs_pkg::ST_RUN;
          end
        end
        default:
        begin
          state_d = scrs_pkg::ST_STAB;
          cnt_d = 12'h000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q <= scrs_pkg::ST_STAB;
      cnt_q <= 12'h000;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Watchdog counter, clocked by recovery counter overflow
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wd_cnt_q <= '0;
    end
    else if (src_any || svc || wd_disable)
    begin
      wd_cnt_q <= '0;
    end
    else if (cnt_ovf)
    begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Reset cause and vector selection
  // ---------------------------------------------------------------
  logic [7:0] cause_q;
  logic monitor_force_q;
  logic [15:0] vector_q;

  // No software clear exists, so a set can never be lost to one.
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cause_q <= `SCRS_CAUSE_RESET;
    end
    else if (por_s)
    begin
      cause_q <= `SCRS_CAUSE_RESET;
    end
    else
    begin
      cause_q[`SCRS_CAUSE_WDT] <= cause_q[`SCRS_CAUSE_WDT] | wd_src;
      cause_q[`SCRS_CAUSE_ILLEGAL_OPCODE_FLAG] <= cause_q[`SCRS_CAUSE_ILLEGAL_OPCODE_FLAG] | illegal_opcode_flag_src;
      cause_q[`SCRS_CAUSE_ILLEGAL_ADDRESS_FLAG] <= cause_q[`SCRS_CAUSE_ILLEGAL_ADDRESS_FLAG] | illegal_address_flag_src;
      cause_q[`SCRS_CAUSE_BLANK] <= cause_q[`SCRS_CAUSE_BLANK] | blank_src;
      cause_q[`SCRS_CAUSE_LVR] <= cause_q[`SCRS_CAUSE_LVR] | lvi_src;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      monitor_force_q <= 1'b0;
    end
    else if (por_s)
    begin
      monitor_force_q <= 1'b0;
    end
    else if (blank_src)
    begin
      monitor_force_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      vector_q <= `SCRS_VEC_USER;
    end
    else
    begin
      vector_q <= (monitor_mode_in || monitor_force_q) ? `SCRS_VEC_MON : `SCRS_VEC_USER;
    end
  end

  // ---------------------------------------------------------------
  // Clock gating and bus clock divider
  // ---------------------------------------------------------------
  logic [1:0] div_q;
  logic [1:0] div_d;
  logic bus_clk_q;
  logic rst_q;
  logic cpu_en_q;
  logic per_en_q;
  logic gen_en_q;
  logic running_d;

  assign running_d = (state_d == scrs_pkg::ST_RUN) || (state_d == scrs_pkg::ST_WAIT);
  assign div_d = running_d ? div_q + 2'b01 : 2'b00;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      div_q <= 2'b00;
      bus_clk_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      bus_clk_q <= div_d[1];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_q <= 1'b1;
      cpu_en_q <= 1'b0;
      per_en_q <= 1'b0;
      gen_en_q <= 1'b0;
    end
    else
    begin
      rst_q <= (state_d == scrs_pkg::ST_STAB) || (state_d == scrs_pkg::ST_TAIL);
      cpu_en_q <= (state_d == scrs_pkg::ST_RUN);
      per_en_q <= running_d;
      gen_en_q <= (state_d != scrs_pkg::ST_STOP);
    end
  end

  assign internal_reset_out = rst_q;
  assign cpu_clk_en_out = cpu_en_q;
  assign periph_clk_en_out = per_en_q;
  assign internal_bus_clock_out = bus_clk_q;
  assign clock_gen_output_out = gen_en_q;
  assign reset_vector_out = vector_q;
  assign monitor_force_out = monitor_force_q;
  assign reset_cause_register_out = cause_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [12:0] stab_len_q;
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stab_len_q <= 13'h0000;
    end
    else if (state_q == scrs_pkg::ST_STAB && !src_any)
    begin
      stab_len_q <= stab_len_q + 13'h0001;
    end
    else
    begin
      stab_len_q <= 13'h0000;
    end
  end

  property p_div4;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    $rose(bus_clk_q) ##1 per_en_q [*4] |-> $rose(bus_clk_q);
  endproperty
  a_div4: assert property (p_div4) else $error("bus clock not quarter rate");

  property p_stab;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state_q == scrs_pkg::ST_STAB && state_d == scrs_pkg::ST_TAIL) |-> stab_len_q == 13'h0FFF;
  endproperty
  a_stab: assert property (p_stab) else $error("stabilisation not 4096 cycles");

  property p_tail;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    $fell(rst_q) |-> $past(rst_q, 64);
  endproperty
  a_tail: assert property (p_tail) else $error("reset tail shorter than 64");

  property p_short_stop;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state_q == scrs_pkg::ST_STOP && wake_in && !src_any && cfg_in.short_stop_recovery)
      |=> (!cpu_en_q) [*8] ##[1:40] (cpu_en_q || rst_q);
  endproperty
  a_short_stop: assert property (p_short_stop) else $error("short stop delay wrong");

  property p_wait;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (run && wait_exec_in && !stop_exec_in && !src_any) |=> !cpu_en_q && per_en_q;
  endproperty
  a_wait: assert property (p_wait) else $error("wait mode gating wrong");

  property p_wdt;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (wd_ovf && !por_s) |=> cause_q[`SCRS_CAUSE_WDT] && rst_q && cnt_q == 12'h000;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset missing");

  property p_por;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    por_s |=> cause_q == `SCRS_CAUSE_RESET && rst_q;
  endproperty
  a_por: assert property (p_por) else $error("power-on cause wrong");

  property p_svc;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (svc && !src_any && !stop_exec_in && !wait_exec_in) |=> wd_cnt_q == '0 && cnt_q[11:4] == 8'h00;
  endproperty
  a_svc: assert property (p_svc) else $error("service write did not clear");

  property p_illegal_opcode_flag;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (run && stop_exec_in && !cfg_in.stop_enable && !long_src)
      |=> cause_q[`SCRS_CAUSE_ILLEGAL_OPCODE_FLAG] && state_q == scrs_pkg::ST_TAIL;
  endproperty
  a_illegal_opcode_flag: assert property (p_illegal_opcode_flag) else $error("disabled stop not illegal");

  property p_data_fetch;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (run && data_fetch_in && !opcode_fetch_in && addr_unmapped_in && !src_any)
      |=> !cause_q[`SCRS_CAUSE_ILLEGAL_ADDRESS_FLAG] || $past(cause_q[`SCRS_CAUSE_ILLEGAL_ADDRESS_FLAG]);
  endproperty
  a_data_fetch: assert property (p_data_fetch) else $error("data fetch caused reset");

  property p_vec;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    $fell(rst_q) |-> (reset_vector_out == `SCRS_VEC_MON) == $past(monitor_mode_in || monitor_force_q);
  endproperty
  a_vec: assert property (p_vec) else $error("reset vector wrong");

  c_por_run: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) $fell(rst_q));
  c_stop_rec: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    state_q == scrs_pkg::ST_STOP_REC ##1 state_q == scrs_pkg::ST_RUN);
  c_wdt: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) wd_ovf);
  c_blank: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) blank_src);

endmodule // scrs_core

/* verif/scrs_cpu_model.sv */
// CPU-side partner of the sequencer: one-cycle CPU events on command and a
// reset vector fetch each time the internal reset is released.
// Assumes commands are set just after a rising edge and held for one cycle.
module scrs_cpu_model (
  input wire logic clk_in,
  input wire logic internal_reset_in,
  input wire logic go_in,
  input wire logic [2:0] cmd_in,
  input wire logic [15:0] wr_addr_in,
  input wire logic blank_in,
  output logic illegal_op_out,
  output logic stop_exec_out,
  output logic wait_exec_out,
  output logic opcode_fetch_out,
  output logic data_fetch_out,
  output logic addr_unmapped_out,
  output logic write_out,
  output logic [15:0] addr_out,
  output logic vector_fetch_out,
  output logic [7:0] vector_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic go_q;
  logic [2:0] cmd_q;
  logic internal_reset_q;

  initial
  begin
    {illegal_op_out, stop_exec_out, wait_exec_out, opcode_fetch_out} = 4'h0;
    {data_fetch_out, addr_unmapped_out, write_out, vector_fetch_out} = 4'h0;
    addr_out = 16'h0000;
    vector_data_out = 8'h00;
    internal_reset_q = 1'b1;
  end

  // Commands are taken at the edge so the bench may change them afterwards.
  always @(posedge clk_in)
  begin
    go_q = go_in;
    cmd_q = cmd_in;
    #2;
    {illegal_op_out, stop_exec_out, wait_exec_out, opcode_fetch_out} = 4'h0;
    {data_fetch_out, addr_unmapped_out, write_out, vector_fetch_out} = 4'h0;
    // Idle buses keep moving so a stale value is never mistaken for data.
    addr_out = ~addr_out;
    vector_data_out = ~vector_data_out;
    if (go_q)
    begin
      case (cmd_q)
        3'h0: illegal_op_out = 1'b1;
        3'h1: stop_exec_out = 1'b1;
        3'h2: wait_exec_out = 1'b1;
        3'h3:
        begin
          write_out = 1'b1;
          addr_out = 16'hFFFF;
        end
        3'h4: {opcode_fetch_out, addr_unmapped_out} = 2'h3;
        3'h5: {data_fetch_out, addr_unmapped_out} = 2'h3;
        default:
        begin
          write_out = 1'b1;
          addr_out = wr_addr_in;
        end
      endcase
    end
    if (internal_reset_q && !internal_reset_in)
    begin
      vector_fetch_out = 1'b1;
      vector_data_out = blank_in ? 8'hFF : 8'h5A;
    end
    internal_reset_q = internal_reset_in;
  end
endmodule // scrs_cpu_model

/* verif/system_clock_reset_sequencer_test.sv */
// Self-checking bench of the sequencer core with a CPU partner model.
// Assumes the core and its package are compiled first; clock is 40 MHz.
module system_clock_reset_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0;
  logic rstn_in;
  logic por_in, lv_in, wdt_in, hv_in;
  logic mon_in, wake_in, go, blank;
  logic [2:0] cmd;
  logic [15:0] wr_addr;
  logic [15:0] lfsr = 16'hA616;
  scrs_pkg::scrs_cfg_s cfg_in;
  logic ill, stp, wt, opf, dtf, unm, wr, vf;
  logic [15:0] addr;
  logic [7:0] vdata;
  logic internal_reset, cpu_en, per_en, bus_clk, gen_en, mon_force, prev;
  logic [15:0] vec;
  logic [7:0] cause;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int compares = 0;
  int n;
  int nb;

  initial
  begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  scrs_core #(.WDT_BITS(2)) scrs_core_inst (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .power_on_pulse_in(por_in),
    .low_voltage_trip_in(lv_in), .watchdog_req_in(wdt_in), .external_irq_pin_hv_in(hv_in),
    .cfg_in(cfg_in), .monitor_mode_in(mon_in), .illegal_op_in(ill), .stop_exec_in(stp),
    .wait_exec_in(wt), .wake_in(wake_in), .opcode_fetch_in(opf), .data_fetch_in(dtf),
    .addr_unmapped_in(unm), .write_in(wr), .addr_in(addr), .vector_fetch_in(vf),
    .vector_data_in(vdata), .internal_reset_out(internal_reset), .cpu_clk_en_out(cpu_en),
    .periph_clk_en_out(per_en), .internal_bus_clock_out(bus_clk),
    .clock_gen_output_out(gen_en), .reset_vector_out(vec), .monitor_force_out(mon_force),
    .reset_cause_register_out(cause));

  scrs_cpu_model scrs_cpu_model_inst (
    .clk_in(clk_sys_in), .internal_reset_in(internal_reset), .go_in(go), .cmd_in(cmd),
    .wr_addr_in(wr_addr), .blank_in(blank), .illegal_op_out(ill), .stop_exec_out(stp),
    .wait_exec_out(wt), .opcode_fetch_out(opf), .data_fetch_out(dtf),
    .addr_unmapped_out(unm), .write_out(wr), .addr_out(addr), .vector_fetch_out(vf),
    .vector_data_out(vdata));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
    #2;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    compares++;
    if (seen !== expv)
    begin
      n_errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Every wait is bounded; running out ends the run with a mismatch.
  task automatic wait_internal_reset(input logic lvl, output int k);
    k = 0;
    while (internal_reset !== lvl && k < 20000)
    begin
      tick(1);
      k++;
    end
    if (k >= 20000)
    begin
      n_errors++;
      $display("[ERR] %0t ns: internal reset wait ran out", $time);
      tally_and_finish();
    end
  endtask

  task automatic cpu(input logic [2:0] c);
    cmd = c;
    go = 1'b1;
    tick(1);
    go = 1'b0;
  endtask

  task automatic reset_len(output int k);
    wait_internal_reset(1'b1, k);
    check(16'({cpu_en, per_en, bus_clk}), 16'h0000);
    wait_internal_reset(1'b0, k);
  endtask

  task automatic stop_wake(input logic short_rec, input int expn);
    cfg_in.stop_enable = 1'b1;
    cfg_in.short_stop_recovery = short_rec;
    cpu(3'h1);
    tick(3);
    check(16'({cpu_en, per_en, gen_en, bus_clk}), 16'h0000);
    wake_in = 1'b1;
    tick(1);
    wake_in = 1'b0;
    n = 0;
    while (cpu_en !== 1'b1 && n < 5000)
    begin
      tick(1);
      n++;
    end
    check(16'(n), 16'(expn));
    if (n >= 5000)
      tally_and_finish();
    cfg_in.stop_enable = 1'b0;
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // --------------------------------------------------------------------------
  // Result watcher: each internal reset consumes the oldest expected cause
  // --------------------------------------------------------------------------
  initial
  begin
    forever
    begin
      @(posedge internal_reset);
      if (rstn_in === 1'b1)
      begin
        tick(2);
        if (exp_q.size() == 0)
        begin
          n_errors++;
          $display("[ERR] %0t ns: reset without a cause", $time);
        end
        else
          check(16'(cause), 16'(exp_q.pop_front()));
      end
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    rstn_in = 1'b0;
    {por_in, lv_in, wdt_in, hv_in} = 4'h0;
    {mon_in, wake_in, go, blank} = 4'h0;
    cmd = 3'h0;
    wr_addr = 16'h0000;
    cfg_in = '0;
    tick(4);
    rstn_in = 1'b1;
    tick(2);
    check(16'({cpu_en, bus_clk, gen_en}), 16'h0001);
    check(16'(cause), 16'h0080);
    check(vec, 16'hFFFE);
    wait_internal_reset(1'b0, n);
    check(16'(n >= 4158 && n <= 4166), 16'h0001);
    done("startup");
    nb = 0;
    prev = bus_clk;
    for (int i = 0; i < 40; i++)
    begin
      tick(1);
      if (bus_clk === 1'b1 && prev === 1'b0)
        nb++;
      prev = bus_clk;
    end
    check(16'(nb), 16'h000A);
    done("bus clock");
    exp_q.push_back(8'h90);
    cpu(3'h0);
    reset_len(n);
    check(16'(n), 16'h0040);
    exp_q.push_back(8'h90);
    cpu(3'h1);
    reset_len(n);
    check(16'(n), 16'h0040);
    cpu(3'h5);
    tick(20);
    exp_q.push_back(8'h98);
    cpu(3'h4);
    reset_len(n);
    check(16'(n), 16'h0040);
    done("cpu resets");
    cpu(3'h2);
    tick(3);
    check(16'({cpu_en, per_en}), 16'h0001);
    wake_in = 1'b1;
    tick(1);
    wake_in = 1'b0;
    tick(2);
    check(16'({cpu_en, per_en}), 16'h0003);
    stop_wake(1'b1, 32);
    stop_wake(1'b0, 4096);
    done("wait and stop");
    blank = 1'b1;
    exp_q.push_back(8'h98);
    exp_q.push_back(8'h9C);
    cpu(3'h0);
    wait_internal_reset(1'b1, n);
    wait_internal_reset(1'b0, n);
    wait_internal_reset(1'b1, n);
    blank = 1'b0;
    wait_internal_reset(1'b0, n);
    tick(2);
    check(vec, 16'hFEFE);
    check(16'(mon_force), 16'h0001);
    done("blank vector");
    mon_in = 1'b1;
    hv_in = 1'b1;
    wdt_in = 1'b1;
    tick(30);
    check(16'(internal_reset), 16'h0000);
    exp_q.push_back(8'hBC);
    hv_in = 1'b0;
    wait_internal_reset(1'b1, n);
    wdt_in = 1'b0;
    mon_in = 1'b0;
    wait_internal_reset(1'b0, n);
    done("watchdog request");
    cfg_in.lv_reset_disable = 1'b1;
    lv_in = 1'b1;
    tick(30);
    check(16'(internal_reset), 16'h0000);
    cfg_in.lv_reset_disable = 1'b0;
    cfg_in.lv_power_disable = 1'b1;
    tick(30);
    check(16'(internal_reset), 16'h0000);
    lv_in = 1'b0;
    tick(3);
    cfg_in.lv_power_disable = 1'b0;
    exp_q.push_back(8'hBE);
    lv_in = 1'b1;
    wait_internal_reset(1'b1, n);
    tick(200);
    check(16'(internal_reset), 16'h0001);
    lv_in = 1'b0;
    wait_internal_reset(1'b0, n);
    check(16'(n >= 4160 && n <= 4170), 16'h0001);
    done("low voltage");
    exp_q.push_back(8'h80);
    por_in = 1'b1;
    wait_internal_reset(1'b1, n);
    tick(10);
    por_in = 1'b0;
    wait_internal_reset(1'b0, n);
    tick(2);
    check(16'({mon_force, gen_en}), 16'h0001);
    check(vec, 16'hFFFE);
    done("power on");
    for (int i = 0; i < 10; i++)
    begin
      lfsr = lfsr_next(lfsr);
      wr_addr = lfsr & 16'hFFFE;
      cpu(3'h6);
      tick(1500 + int'(lfsr[7:0]));
      cpu(3'h3);
      tick(1);
    end
    exp_q.push_back(8'hA0);
    wait_internal_reset(1'b1, n);
    check(16'(n >= 16368 && n <= 16400), 16'h0001);
    wait_internal_reset(1'b0, n);
    tick(4);
    check(16'(exp_q.size()), 16'h0000);
    done("watchdog service and overflow");
    tally_and_finish();
  end
endmodule // system_clock_reset_sequencer_test
